// [shared/lbci_pkg.sv]
// constants and types of the link boot command interpreter
// Notes on behaviour
// - commands on any link, reply same link
// - 'b', count, payload stored as boot
// - 'c', count, payload stored as config
// - 'e' plus device number erases device
// - 'r' address count returns stored bytes
// - 'w' address count data programs bytes
// - 's' status, 'v' version, 'x' reboot
// - chained modules form one address space
// - stored content is never executed
// - programming voltage only during program/erase
// - voltage forced off at power-up, fail
// - power fail kills voltage, resets controller
// - power fail deasserts reset and analyse
// - power return: hold, pulse reset, reboot
// - drive reset/analyse, monitor combined error
// - link jumper pairs: low bit, high bit
// - mode jumpers sampled only at reset
// - 262128 user bytes per module
// - no reprogram of non-FF, skip erased
// - after boot enter command mode
package lbci_pkg;
   // apb register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_LINK = 8'h08;
   localparam logic [7:0] REG_VER  = 8'h0C;
   // field positions
   localparam int CTRL_ANA_BIT    = 0;
   localparam int CTRL_REBOOT_BIT = 1;
   localparam int STAT_VPP_BIT    = 2;
   localparam int STAT_CERR_BIT   = 3;
   localparam int STAT_SSERR_BIT  = 4;
   localparam int STAT_PWROK_BIT  = 5;
   localparam int STAT_ST_LSB     = 8;
   // command opcodes
   localparam logic [7:0] OP_BOOT   = 8'h62;
   localparam logic [7:0] OP_CFG    = 8'h63;
   localparam logic [7:0] OP_ERASE  = 8'h65;
   localparam logic [7:0] OP_READ   = 8'h72;
   localparam logic [7:0] OP_STAT   = 8'h73;
   localparam logic [7:0] OP_VER    = 8'h76;
   localparam logic [7:0] OP_WRITE  = 8'h77;
   localparam logic [7:0] OP_REBOOT = 8'h78;
   // storage layout
   localparam logic [31:0] USER_BYTES  = 32'h0003_FFF0;
   localparam logic [31:0] BOOT_BASE   = 32'h0000_0000;
   localparam logic [31:0] CFG_BASE    = 32'h0002_0000;
   localparam logic [2:0]  HDR_BYTES   = 3'h4;
   localparam int          MAX_MODS    = 4;
   localparam int          DEVS_PER    = 4;
   localparam int          DEV_SHIFT   = 16;
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;
   localparam logic [7:0]  REPLY_OK    = 8'h00;
   localparam logic [7:0]  REPLY_REF   = 8'h01;
   localparam logic [31:0] EMPTY_LEN   = 32'hFFFF_FFFF;
   // timing
   localparam int CLK_MHZ      = 100;
   localparam int POR_HOLD_US  = 5000;
   localparam int SSRST_US     = 100;
   localparam int POR_CYC      = POR_HOLD_US * CLK_MHZ;
   localparam int SSRST_CYC    = SSRST_US * CLK_MHZ;
   localparam int TMR_W        = 20;

   typedef enum logic [1:0] {
      MODE_BOOT   = 2'b00,
      MODE_TRANSP = 2'b01,
      MODE_UNDEF  = 2'b10,
      MODE_AUTO   = 2'b11
   } lbci_mode_e;

   typedef enum logic [3:0] {
      ST_HOLD  = 4'b0000, ST_SSRST = 4'b0001, ST_IDLE   = 4'b0010, ST_FIELD = 4'b0011,
      ST_DATA  = 4'b0100, ST_CHK   = 4'b0101, ST_PGM    = 4'b0110, ST_ERASE = 4'b0111,
      ST_RD    = 4'b1000, ST_SEND  = 4'b1001, ST_TRANSP = 4'b1010, ST_BHDR  = 4'b1011,
      ST_DEAD  = 4'b1100
   } lbci_state_e;

   typedef struct packed {
      lbci_state_e              st;
      lbci_state_e              ret;
      lbci_mode_e               mode;
      logic [1:0]               link_a;
      logic [1:0]               link_b;
      logic [1:0]               cur;
      logic [7:0]               op;
      logic [31:0]              fld;
      logic [31:0]              addr;
      logic [31:0]              cnt;
      logic [2:0]               nfld;
      logic                     phase;
      logic [2:0]               hdr;
      logic                     cmd_err;
      logic                     vpp;
      logic                     ss_rst;
      logic                     ss_ana;
      logic                     ctl_ana;
      logic [TMR_W-1:0]         tmr;
      logic [15:0]              erased;
      logic                     tx_pend;
      logic [1:0]               tx_link;
      logic [7:0]               tx_data;
      logic                     fl_req;
      logic                     fl_we;
      logic                     fl_erase;
      logic [1:0]               fl_mod;
      logic [17:0]              fl_addr;
      logic [7:0]               fl_wdata;
      logic [7:0]               sy1;
      logic [7:0]               sy2;
      logic [31:0]              prdata;
   } lbci_state_s;
endpackage : lbci_pkg

// [verilog/lbci_top.sv]
// link boot command interpreter with apb status/control slave
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module lbci_top
   import lbci_pkg::*;
#(
   parameter int          MODULES   = 1,
   parameter int          POR_CYCS  = POR_CYC,
   parameter int          SSRST_CYCS = SSRST_CYC,
   parameter logic [15:0] FW_VERSION = 16'h0101  // arbitrary value
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  link_rx_valid,
   input  wire logic [31:0] link_rx_data,
   output logic [3:0]       link_rx_ready,
   output logic [3:0]       link_tx_valid,
   output logic [31:0]      link_tx_data,
   input  wire logic [3:0]  link_tx_ready,
   output logic             fl_req,
   output logic             fl_we,
   output logic             fl_erase,
   output logic [1:0]       fl_mod,
   output logic [17:0]      fl_addr,
   output logic [7:0]       fl_wdata,
   input  wire logic [7:0]  fl_rdata,
   input  wire logic        fl_ack,
   output logic             vpp_en,
   output logic             ss_reset,
   output logic             ss_analyse,
   input  wire logic        ss_error_n,
   input  wire logic        pwr_fail_n,
   input  wire logic        link_sel_a_low_jumper,
   input  wire logic        link_sel_a_high_jumper,
   input  wire logic        link_sel_b_low_jumper,
   input  wire logic        link_sel_b_high_jumper,
   input  wire logic        mode_sel_low_jumper,
   input  wire logic        mode_sel_high_jumper
);
   localparam logic [31:0] LIMIT = 32'(USER_BYTES * MODULES);
   localparam logic [15:0] NDEVS = 16'(MODULES * DEVS_PER);

   lbci_state_s q;
   lbci_state_s n;
   logic        rx_take;
   logic [1:0]  rx_sel;

   // chain looks like one address space
   function automatic logic [19:0] split(input logic [31:0] a);
      logic [31:0] r;
      logic [1:0]  m;
      r = a;
      m = 2'h0;
      for (int i = 0; i < MAX_MODS - 1; i++) begin
         if (r >= USER_BYTES) begin
            r = r - USER_BYTES;
            m = m + 2'h1;
         end
      end
      return {m, r[17:0]};
   endfunction : split

   // start a flash byte access
   function automatic lbci_state_s fl_issue(input lbci_state_s s, input logic we,
                                            input logic [7:0] wd);
      lbci_state_s r;
      r = s;
      r.fl_req = 1'b1;
      r.fl_we = we;
      r.fl_erase = 1'b0;
      {r.fl_mod, r.fl_addr} = split(s.addr);
      r.fl_wdata = wd;
      return r;
   endfunction : fl_issue

   // queue a reply byte
   function automatic lbci_state_s send(input lbci_state_s s, input logic [7:0] b,
                                        input lbci_state_e ret);
      lbci_state_s r;
      r = s;
      r.tx_pend = 1'b1;
      r.tx_link = s.cur;
      r.tx_data = b;
      r.st = ST_SEND;
      r.ret = ret;
      return r;
   endfunction : send

   // status word; low byte is the status reply
   function automatic logic [31:0] stat_word(input lbci_state_s s);
      logic [31:0] w;
      w = 32'h0;
      w[1:0] = s.mode;
      w[STAT_VPP_BIT] = s.vpp;
      w[STAT_CERR_BIT] = s.cmd_err;
      w[STAT_SSERR_BIT] = ~s.sy2[6];
      w[STAT_PWROK_BIT] = s.sy2[7];
      w[STAT_ST_LSB +: 4] = s.st;
      return w;
   endfunction : stat_word

   // whole next-state computation
   always_comb begin
      logic [7:0]  b;
      logic [31:0] f;
      logic [31:0] v;
      logic [19:0] sp;
      logic [15:0] dev;
      logic        pok;
      b = 8'h0;
      f = 32'h0;
      v = 32'h0;
      sp = 20'h0;
      dev = 16'h0;
      n = q;
      rx_take = 1'b0;
      rx_sel = q.cur;
      // pins pass two flops before use
      n.sy1 = {pwr_fail_n, ss_error_n, mode_sel_high_jumper, mode_sel_low_jumper,
               link_sel_b_high_jumper, link_sel_b_low_jumper,
               link_sel_a_high_jumper, link_sel_a_low_jumper};
      n.sy2 = q.sy1;
      pok = q.sy2[7];
      if (q.tx_pend && link_tx_ready[q.tx_link]) begin
         n.tx_pend = 1'b0;
      end
      // read data captured in setup, zero waits
      if (psel && !penable) begin
         unique case (paddr)
            REG_CTRL: n.prdata = {30'h0, 1'b0, q.ctl_ana};
            REG_STAT: n.prdata = stat_word(q);
            REG_LINK: n.prdata = {28'h0, q.link_b, q.link_a};
            REG_VER:  n.prdata = {16'h0, FW_VERSION};
            default:  n.prdata = 32'h0;
         endcase
      end
      // clear loses to a same-cycle set
      if (psel && penable && pwrite && paddr == REG_STAT && pwdata[STAT_CERR_BIT]) begin
         n.cmd_err = 1'b0;
      end
      if (psel && penable && pwrite && paddr == REG_CTRL) begin
         n.ctl_ana = pwdata[CTRL_ANA_BIT];
      end
      unique case (q.st)
         ST_HOLD: begin
            n.ss_rst = 1'b0;
            if (q.tmr == TMR_W'(POR_CYCS - 1)) begin
               n.tmr = '0;
               n.link_a = q.sy2[1:0];
               n.link_b = q.sy2[3:2];
               n.mode = lbci_mode_e'(q.sy2[5:4]);
               n.ss_rst = 1'b1;
               n.st = ST_SSRST;
            end else begin
               n.tmr = q.tmr + TMR_W'(1);
            end
         end
         ST_SSRST: begin
            n.ss_rst = 1'b1;
            if (q.tmr == TMR_W'(SSRST_CYCS - 1)) begin
               n.tmr = '0;
               n.ss_rst = 1'b0;
               n.hdr = 3'h0;
               n.addr = BOOT_BASE;
               n.cur = q.link_a;
               unique case (q.mode)
                  MODE_BOOT:   n.st = ST_BHDR;
                  MODE_TRANSP: n.st = ST_TRANSP;
                  MODE_AUTO:   n.st = ST_IDLE;
                  MODE_UNDEF:  n.st = ST_DEAD;
               endcase
            end else begin
               n.tmr = q.tmr + TMR_W'(1);
            end
         end
         ST_BHDR: begin
            // header, then image streamed, never run
            if (q.fl_req && fl_ack) begin
               n.fl_req = 1'b0;
               f = {fl_rdata, q.fld[31:8]};
               n.fld = f;
               n.hdr = q.hdr + 3'h1;
               n.addr = q.addr + 32'h1;
               if (q.hdr == HDR_BYTES - 3'h1) begin
                  n.cnt = f;
                  n.st = (f == EMPTY_LEN) ? ST_IDLE : ST_RD;
               end
            end else if (!q.fl_req) begin
               n = fl_issue(n, 1'b0, 8'h0);
            end
         end
         ST_IDLE: begin
            for (int i = 3; i >= 0; i--) begin
               if (link_rx_valid[i]) begin
                  rx_sel = 2'(i);
               end
            end
            if (|link_rx_valid) begin
               rx_take = 1'b1;
               b = link_rx_data[{rx_sel, 3'b000} +: 8];
               n.cur = rx_sel;
               n.op = b;
               n.nfld = 3'h4;
               n.phase = 1'b1;
               n.hdr = 3'h0;
               unique case (b)
                  OP_BOOT: begin
                     n.addr = BOOT_BASE;
                     n.st = ST_FIELD;
                  end
                  OP_CFG: begin
                     n.addr = CFG_BASE;
                     n.st = ST_FIELD;
                  end
                  OP_ERASE, OP_VER: begin
                     n.nfld = 3'h2;
                     n.st = ST_FIELD;
                  end
                  OP_READ, OP_WRITE: begin
                     n.phase = 1'b0;
                     n.hdr = HDR_BYTES;
                     n.st = ST_FIELD;
                  end
                  OP_STAT: n = send(n, stat_word(q)[7:0], ST_IDLE);
                  OP_REBOOT: begin
                     n.tmr = '0;
                     n.ss_rst = 1'b1;
                     n.st = ST_SSRST;
                  end
                  default: n.st = ST_IDLE;
               endcase
            end
         end
         ST_FIELD: begin
            if (link_rx_valid[q.cur]) begin
               rx_take = 1'b1;
               f = {link_rx_data[{q.cur, 3'b000} +: 8], q.fld[31:8]};
               n.fld = f;
               n.nfld = q.nfld - 3'h1;
               if (q.nfld == 3'h1) begin
                  v = (q.op == OP_ERASE || q.op == OP_VER) ? (f >> 16) : f;
                  n.fld = v;
                  if (!q.phase) begin
                     n.addr = v;
                     n.phase = 1'b1;
                     n.nfld = 3'h4;
                  end else if (q.op == OP_ERASE) begin
                     n.st = ST_ERASE;
                  end else if (q.op == OP_VER) begin
                     n = send(n, FW_VERSION[7:0], ST_IDLE);
                  end else if (q.op == OP_READ) begin
                     n.cnt = v;
                     n.st = ST_RD;
                  end else begin
                     n.cnt = v;
                     n.vpp = 1'b1;
                     n.st = ST_DATA;
                  end
               end
            end
         end
         ST_DATA: begin
            // boot/config: length header first, then payload; write: payload only
            if (q.hdr < HDR_BYTES) begin
               n.fl_wdata = 8'(q.fld >> {q.hdr[1:0], 3'b000});
               n.hdr = q.hdr + 3'h1;
               n.st = ST_CHK;
            end else if (q.cnt == 32'h0) begin
               n.vpp = 1'b0;
               n = send(n, q.cmd_err ? REPLY_REF : REPLY_OK, ST_IDLE);
            end else if (link_rx_valid[q.cur]) begin
               rx_take = 1'b1;
               n.fl_wdata = link_rx_data[{q.cur, 3'b000} +: 8];
               n.cnt = q.cnt - 32'h1;
               n.st = ST_CHK;
            end
         end
         ST_CHK: begin
            // blank check before each byte; a slow read is traded for safety
            if (q.fl_req && fl_ack) begin
               n.fl_req = 1'b0;
               if (fl_rdata != ERASED_BYTE) begin
                  n.cmd_err = 1'b1;
                  n.addr = q.addr + 32'h1;
                  n.st = ST_DATA;
               end else begin
                  n = fl_issue(n, 1'b1, q.fl_wdata);
                  n.st = ST_PGM;
               end
            end else if (!q.fl_req && q.addr >= LIMIT) begin
               n.cmd_err = 1'b1;
               n.addr = q.addr + 32'h1;
               n.st = ST_DATA;
            end else if (!q.fl_req) begin
               n = fl_issue(n, 1'b0, q.fl_wdata);
            end
         end
         ST_PGM: begin
            if (q.fl_req && fl_ack) begin
               sp = split(q.addr);
               n.fl_req = 1'b0;
               n.erased[{sp[19:18], sp[DEV_SHIFT +: 2]}] = 1'b0;
               n.addr = q.addr + 32'h1;
               n.st = ST_DATA;
            end
         end
         ST_ERASE: begin
            dev = q.fld[15:0];
            if (q.fl_req) begin
               if (fl_ack) begin
                  n.fl_req = 1'b0;
                  n.vpp = 1'b0;
                  n.erased[dev[3:0]] = 1'b1;
                  n = send(n, REPLY_OK, ST_IDLE);
               end
            end else if (dev >= NDEVS) begin
               n.cmd_err = 1'b1;
               n = send(n, REPLY_REF, ST_IDLE);
            end else if (q.erased[dev[3:0]]) begin
               n = send(n, REPLY_OK, ST_IDLE);
            end else begin
               n.vpp = 1'b1;
               n.fl_req = 1'b1;
               n.fl_we = 1'b0;
               n.fl_erase = 1'b1;
               n.fl_mod = dev[3:2];
               n.fl_addr = {dev[1:0], 16'h0};
            end
         end
         ST_RD: begin
            if (q.fl_req) begin
               if (fl_ack) begin
                  n.fl_req = 1'b0;
                  n.addr = q.addr + 32'h1;
                  n.cnt = q.cnt - 32'h1;
                  n = send(n, fl_rdata, ST_RD);
               end
            end else if (q.cnt == 32'h0) begin
               n.st = ST_IDLE;
            end else if (q.addr >= LIMIT) begin
               n.addr = q.addr + 32'h1;
               n.cnt = q.cnt - 32'h1;
               n = send(n, ERASED_BYTE, ST_RD);
            end else begin
               n = fl_issue(n, 1'b0, 8'h0);
            end
         end
         ST_SEND: begin
            if (!q.tx_pend) begin
               n.st = q.ret;
            end
         end
         ST_TRANSP: begin
            // one byte in flight at a time
            if (!q.tx_pend) begin
               if (link_rx_valid[q.link_a]) begin
                  rx_take = 1'b1;
                  rx_sel = q.link_a;
                  n.cur = q.link_b;
                  n = send(n, link_rx_data[{q.link_a, 3'b000} +: 8], ST_TRANSP);
               end else if (link_rx_valid[q.link_b]) begin
                  rx_take = 1'b1;
                  rx_sel = q.link_b;
                  n.cur = q.link_a;
                  n = send(n, link_rx_data[{q.link_b, 3'b000} +: 8], ST_TRANSP);
               end
            end
         end
         ST_DEAD: n.st = ST_DEAD;
         default: n.st = ST_HOLD;
      endcase
      // software reboot aborts any command
      if (psel && penable && pwrite && paddr == REG_CTRL && pwdata[CTRL_REBOOT_BIT]
          && q.st != ST_HOLD) begin
         n.fl_req = 1'b0;
         n.vpp = 1'b0;
         n.tmr = '0;
         n.ss_rst = 1'b1;
         n.st = ST_SSRST;
      end
      // power fail wins, restarts the hold
      if (!pok) begin
         n.st = ST_HOLD;
         n.tmr = '0;
         n.vpp = 1'b0;
         n.ss_rst = 1'b0;
         n.fl_req = 1'b0;
         n.tx_pend = 1'b0;
      end
      n.ss_ana = n.ctl_ana & pok;
   end

   // state register; reset lands in hold, voltage off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // outputs
   assign prdata        = q.prdata;
   assign pready        = 1'b1;
   assign pslverr       = psel && penable && paddr != REG_CTRL && paddr != REG_STAT
                          && paddr != REG_LINK && paddr != REG_VER;
   assign link_rx_ready = rx_take ? (4'h1 << rx_sel) : 4'h0;
   assign link_tx_valid = q.tx_pend ? (4'h1 << q.tx_link) : 4'h0;
   assign link_tx_data  = {4{q.tx_data}};
   assign fl_req        = q.fl_req;
   assign fl_we         = q.fl_we;
   assign fl_erase      = q.fl_erase;
   assign fl_mod        = q.fl_mod;
   assign fl_addr       = q.fl_addr;
   assign fl_wdata      = q.fl_wdata;
   assign vpp_en        = q.vpp;
   assign ss_reset      = q.ss_rst;
   assign ss_analyse    = q.ss_ana;
endmodule : lbci_top

// [test/lbci_props.sv]
// assertion checker of the command interpreter
`timescale 1ns/10ps
module lbci_props (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pslverr,
   input logic [3:0]  link_rx_ready,
   input logic [3:0]  link_tx_valid,
   input logic [31:0] link_tx_data,
   input logic [3:0]  link_tx_ready,
   input logic        fl_req,
   input logic        fl_we,
   input logic        fl_erase,
   input logic        fl_ack,
   input logic [17:0] fl_addr,
   input logic        vpp_en,
   input logic        ss_reset,
   input logic        ss_analyse,
   input logic        pwr_fail_n
);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   // allow for the synchroniser delay
   a_pwr_fail_off:
   assert property ($fell(pwr_fail_n) |-> ##[0:4] (!vpp_en && !ss_reset && !ss_analyse))
      else $error("power loss");
   a_pwr_held_off:
   assert property ((!pwr_fail_n) [*4] |-> !vpp_en && !ss_reset && !ss_analyse)
      else $error("power down");
   // no flash change without the voltage
   a_vpp_on_program:
   assert property (fl_req && (fl_we || fl_erase) && !fl_ack |=> vpp_en)
      else $error("no voltage");
   a_tx_one_link:
   assert property ($onehot0(link_tx_valid)) else $error("two tx links");
   a_rx_one_link:
   assert property ($onehot0(link_rx_ready)) else $error("two rx links");
   a_tx_byte_held:
   assert property (|link_tx_valid && !(|(link_tx_valid & link_tx_ready))
      |=> $stable(link_tx_valid) && $stable(link_tx_data)) else $error("reply dropped");
   a_flash_req_held:
   assert property (fl_req && !fl_ack |=> fl_req && $stable(fl_addr) && $stable({fl_we, fl_erase}))
      else $error("flash req moved");
   a_slverr_access:
   assert property (pslverr |-> psel && penable) else $error("stray slverr");
endmodule : lbci_props

bind lbci_top lbci_props u_props (.*);

// [test/lbci_flash_model.sv]
// flash array answering byte requests
`timescale 1ns/10ps
module lbci_flash_model
   import lbci_pkg::*;
(
   input  logic        pclk,
   input  logic        slow,
   input  logic        fl_req,
   input  logic        fl_we,
   input  logic        fl_erase,
   input  logic [17:0] fl_addr,
   input  logic [7:0]  fl_wdata,
   output logic [7:0]  fl_rdata = 8'h00,
   output logic        fl_ack = 1'b0
);
   logic [7:0] mem [0:262143];
   int         wt = 0;
   initial for (int i = 0; i < 262144; i++) mem[i] = ERASED_BYTE;
   // one ack, then a dead cycle: a held request is not taken twice
   always @(posedge pclk) begin
      fl_rdata <= ~fl_rdata;  // data meaningless outside the ack
      if (fl_ack || !fl_req) begin
         fl_ack <= 1'b0;
         wt <= 0;
      end else if (wt < (slow ? 5 : 0)) wt <= wt + 1;
      else begin
         fl_ack <= 1'b1;
         fl_rdata <= mem[fl_addr];
         if (fl_erase) for (int i = 0; i < 65536; i++) mem[{fl_addr[17:16], 16'(i)}] <= 8'hFF;
         else if (fl_we) mem[fl_addr] <= mem[fl_addr] & fl_wdata;  // cells only clear
      end
   end
endmodule : lbci_flash_model

// [test/tb_link_boot_rom_command_interpreter.sv]
// self-checking bench for the link boot command interpreter
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
   $display("BAD %s exp %h seen %h", n, e, s); end end
module tb_link_boot_rom_command_interpreter;
   import lbci_pkg::*;
   localparam logic [15:0] VER = 16'h5A3C;  // arbitrary value
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        slow = 1'b0, ss_error_n = 1'b1, pwr_fail_n = 1'b1, e, pready, pslverr;
   logic        fl_req, fl_we, fl_erase, fl_ack, vpp_en, ss_reset, ss_analyse;
   logic [7:0]  paddr = '0, fl_rdata, fl_wdata, b, pk[$];
   logic [31:0] pwdata = '0, prdata, link_rx_data = '0, link_tx_data, r, a, d;
   logic [3:0]  link_rx_valid = '0, link_rx_ready, link_tx_valid, link_tx_ready = '0;
   logic [1:0]  fl_mod;
   logic [17:0] fl_addr;
   logic        link_sel_a_low_jumper = 1'b1, link_sel_a_high_jumper = 1'b0;
   logic        link_sel_b_low_jumper = 1'b0, link_sel_b_high_jumper = 1'b1;
   logic        mode_sel_low_jumper = 1'b0, mode_sel_high_jumper = 1'b0;
   integer      seed = 32'h9AB16469;
   int          fails = 0, n_tests = 0, k, n, wt;
   lbci_top #(.POR_CYCS(20), .SSRST_CYCS(8), .FW_VERSION(VER)) uut (.*);
   lbci_flash_model fm (.*);
   // far side stalls at random
   always #5 pclk = ~pclk;
   always @(posedge pclk) link_tx_ready <= 4'($random(seed));
   function automatic logic [7:0] stat(input logic err);
      return {2'b00, 1'b1, err, 4'h0};  // boot mode, power good, no voltage
   endfunction : stat
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   task automatic give_up(input int c);
      if (c >= 5000) begin
         fails++;
         report_and_stop();
      end
   endtask : give_up
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (wt = 0; wt < 5000; wt++) begin
         @(posedge pclk);
         if (pready) break;
      end
      give_up(wt);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic put(input logic [31:0] v, input int c);
      for (int i = 0; i < c; i++) pk.push_back(v[8*i +: 8]);
   endtask : put
   // command on a random link, valid held
   task automatic cmd;
      k = $unsigned($random(seed)) % 4;
      slow <= 1'($random(seed));
      foreach (pk[i]) begin
         link_rx_valid[k] <= 1'b1;
         link_rx_data[8*k +: 8] <= pk[i];
         for (wt = 0; wt < 5000; wt++) begin
            @(posedge pclk);
            if (link_rx_ready[k]) break;
         end
         give_up(wt);
      end
      link_rx_valid[k] <= 1'b0;
      link_rx_data[8*k +: 8] <= ~pk[pk.size()-1];
      pk = {};
   endtask : cmd
   task automatic rx(input int lk);
      for (wt = 0; wt < 5000; wt++) begin
         @(posedge pclk);
         if (link_tx_valid[lk] && link_tx_ready[lk]) break;
      end
      give_up(wt);
      b = link_tx_data[8*lk +: 8];
      `CHK("reply link", 4'(1 << lk), link_tx_valid)
   endtask : rx
   task automatic rst_pulse;
      for (wt = 0; wt < 5000 && !ss_reset; wt++) @(posedge pclk);
      give_up(wt);
      for (n = 0; ss_reset && n < 5000; n++) @(posedge pclk);
      `CHK("reset width", 8, n)
   endtask : rst_pulse
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rst_pulse();
      apb(1'b0, REG_LINK, '0);
      `CHK("link map", 32'h0000_0009, r)
      apb(1'b0, REG_VER, '0);
      `CHK("version reg", {16'h0000, VER}, r)
      apb(1'b0, 8'h10, '0);
      `CHK("unmapped", 33'h1_0000_0000, {e, r})
      apb(1'b1, REG_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      `CHK("analyse", 1'b1, ss_analyse)
      apb(1'b1, REG_CTRL, 32'h0);
      ss_error_n <= 1'b0;
      repeat (4) @(posedge pclk);
      pk = {OP_STAT};
      cmd();
      rx(k);
      `CHK("status", stat(1'b1), b)
      ss_error_n <= 1'b1;
      pk = {OP_VER};
      put(32'($random(seed)), 2);
      cmd();
      rx(k);
      `CHK("fw version", VER[7:0], b)
      pk = {8'h71, OP_STAT};  // junk opcode first
      cmd();
      rx(k);
      `CHK("after junk", stat(1'b0), b & 8'hF7)
      // device 0 exists, device 4 is past the single module
      for (int i = 0; i < 2; i++) begin
         pk = {OP_ERASE};
         put(32'(i * 4), 2);
         cmd();
         rx(k);
         `CHK("erase reply", 8'(i), b)
      end
      apb(1'b1, REG_STAT, 32'h8);
      a = 32'h100 + 32'($unsigned($random(seed)) % 256);
      d = $random(seed) & 32'h7F7F7F7F;
      // pass 2 hits programmed bytes
      for (int i = 0; i < 2; i++) begin
         pk = {OP_WRITE};
         put(a, 4);
         put(32'h4, 4);
         put(d, 4);
         cmd();
         rx(k);
         `CHK("write reply", 8'(i), b)
      end
      `CHK("stored low", d[7:0], fm.mem[a[17:0]])
      pk = {OP_READ};
      put(a, 4);
      put(32'h4, 4);
      cmd();
      for (int i = 0; i < 4; i++) begin
         rx(k);
         `CHK("read back", d[8*i +: 8], b)
      end
      apb(1'b1, REG_STAT, 32'h8);
      d = $random(seed);
      pk = {OP_BOOT};
      put(32'h3, 4);
      put(d, 3);
      cmd();
      rx(k);
      `CHK("boot reply", 8'h00, b)
      `CHK("boot length", 8'h03, fm.mem[0])
      pk = {OP_CFG};
      put(32'h2, 4);
      put(d, 2);
      cmd();
      rx(k);
      `CHK("config byte", d[15:8], fm.mem[CFG_BASE[17:0] + 18'h5])
      pk = {OP_REBOOT};
      cmd();
      rst_pulse();
      for (int i = 0; i < 3; i++) begin
         rx(1);
         `CHK("boot stream", d[8*i +: 8], b)
      end
      pk = {OP_STAT};
      cmd();
      rx(k);
      `CHK("command mode", stat(1'b0), b & 8'hF7)
      // jumper change waits for reset
      mode_sel_low_jumper <= 1'b1;
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_STAT, '0);
      `CHK("mode kept", 2'b00, r[1:0])
      pwr_fail_n <= 1'b0;
      repeat (10) @(posedge pclk);
      `CHK("power down", 3'b000, {vpp_en, ss_reset, ss_analyse})
      pwr_fail_n <= 1'b1;
      rst_pulse();
      apb(1'b0, REG_STAT, '0);
      `CHK("mode taken", 2'b01, r[1:0])
      report_and_stop();
   end
endmodule : tb_link_boot_rom_command_interpreter
